// *** bus_monitor_params.svh ***
// constants of the backplane bus monitor: offsets, fields, resets, times
`ifndef BUS_MONITOR_PARAMS_SVH
`define BUS_MONITOR_PARAMS_SVH

// register byte offsets
`define OFS_ADDR_CFG   8'h00
`define OFS_OPT_CFG    8'h04
`define OFS_STATUS     8'h08
`define OFS_CLEAR      8'h0C

// address configuration fields (one byte each)
`define FLD_RD_ADDR    0
`define FLD_WR_ADDR    8
`define FLD_LST_A      16
`define FLD_LST_B      24

// option fields
`define FLD_TSEL       0
`define FLD_PMS_EN     4
`define FLD_ACK_TO_EN  5

// status fields
`define FLD_FLT_DATA   0
`define FLD_FLT_ADDR   1
`define FLD_FLT_CTRL   2
`define FLD_GROUP      3
`define FLD_INHIBIT    4
`define FLD_PATTERN    8

// reset values
`define RST_ADDR_CFG   32'hAA55_7F7F
`define RST_OPT_CFG    6'h30
`define RST_PATTERN    8'h55
`define PATTERN_ALT    8'hAA

// timing
`define CLK_MHZ        100
`define MON_MS_MIN     125

`endif

// *** bus_monitor_pkg.sv ***
// types shared by the backplane bus monitor
package bus_monitor_pkg;
	typedef logic [7:0] byte_t;
	// index of each watchdog timer
	typedef enum logic [1:0] {
		TMR_DATA = 2'h0,
		TMR_LSTA = 2'h1,
		TMR_LSTB = 2'h2,
		TMR_PMS  = 2'h3
	} timer_e;
	typedef struct packed {
		logic ctrl;
		logic addr;
		logic data;
	} faults_s;
endpackage : bus_monitor_pkg

// *** sync2.sv ***
// two-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r <= INIT;
			q      <= INIT;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : sync2

// *** watch_timer.sv ***
// watchdog counter: expires when no restart arrives within the limit
`timescale 1ns/10ps
module watch_timer #(
	parameter int CW = 27
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          restart,
	input  wire logic [CW-1:0] limit,
	output logic               expired
);
	logic [CW-1:0] count_r;

	// count up, saturate at the limit, start again on restart
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_r <= '0;
		end else if (restart) begin
			count_r <= '0;
		end else if (count_r < limit) begin
			count_r <= count_r + 1'b1;
		end
	end

	assign expired = (count_r >= limit) && !restart;
endmodule : watch_timer

// *** bus_monitor.sv ***
// backplane bus monitor with an AHB-Lite register slave
//
// Summary of operation
// - power clear active clears all faults
// - output inhibit trailing edge clears faults
// - external reset input clears faults
// - acknowledge pattern read and write addresses
// - listen addresses observed, never acknowledged
// - read addr on read, write on write
// - byte addresses compared on eight lines
// - rocker n weights address line n-1
// - monitoring time 125 ms up to 1 s
// - no time selected gives 1 s
// - option off keeps acknowledging after fault
// - output inhibit always forces acknowledge
// - select line check can be disabled
// - pattern 55H/AAH inverted after correct write
// - missing pattern write sets data fault
// - missing listen access sets address fault
// - strobe, acknowledge, select misuse sets control fault
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`include "bus_monitor_params.svh"
module bus_monitor
	import bus_monitor_pkg::*;
#(
	parameter int MON_CYC_MIN = `MON_MS_MIN * 1000 * `CLK_MHZ
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [7:0]  bus_addr,
	input  wire logic [7:0]  bus_data_in,
	output logic      [7:0]  bus_data_out,
	output logic             bus_data_oe,
	input  wire logic        read_strobe_n,
	input  wire logic        write_strobe_n,
	input  wire logic        bus_ack_in_n,
	output logic             bus_ack_out_n,
	output logic             bus_ack_oe,
	input  wire logic        periph_mem_select,
	input  wire logic        power_clear_n,
	input  wire logic        output_inhibit,
	input  wire logic        ext_reset,
	output logic             data_fault,
	output logic             addr_fault,
	output logic             ctrl_fault,
	output logic             group_fault
);
	localparam int CW = 27;
	localparam logic [CW-1:0] UNIT = CW'(MON_CYC_MIN);

	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [7:0] addr_s;
	logic [7:0] data_s;
	logic [5:0] ctl_s;
	logic       rd_act;
	logic       wr_act;
	logic       ack_act;
	logic       pms_s;
	logic       pclr_act;
	logic       pclr_n_s;
	logic       inh_s;
	logic       xrst_s;

	sync2 #(.W(8), .INIT(8'h00)) u_sync_addr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (bus_addr),
		.q       (addr_s)
	);
	sync2 #(.W(8), .INIT(8'h00)) u_sync_data (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (bus_data_in),
		.q       (data_s)
	);
	sync2 #(.W(6), .INIT(6'h0F)) u_sync_ctl (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       ({ext_reset, output_inhibit, periph_mem_select,
		            bus_ack_in_n, write_strobe_n, read_strobe_n}),
		.q       (ctl_s)
	);

	assign rd_act   = !ctl_s[0];
	assign wr_act   = !ctl_s[1];
	assign ack_act  = !ctl_s[2];
	assign pms_s    = ctl_s[3];
	assign inh_s    = ctl_s[4];
	assign xrst_s   = ctl_s[5];

	// power clear line is active low on the backplane
	sync2 #(.W(1), .INIT(1'b0)) u_sync_pclr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (power_clear_n),
		.q       (pclr_n_s)
	);

	// inverted only after the second flop, so no logic sees the raw pin
	assign pclr_act = !pclr_n_s;

	////////////////////////////////////////////////////////////////////
	// configuration registers
	logic [31:0] addr_cfg_r;
	logic [5:0]  opt_cfg_r;
	logic        sw_clear;
	byte_t       rd_addr;
	byte_t       wr_addr;
	byte_t       lst_a;
	byte_t       lst_b;
	logic [3:0]  tsel;
	logic        pms_en;
	logic        ack_to_en;

	// bit n-1 of each byte is rocker n, weight 2**(n-1)
	assign rd_addr   = addr_cfg_r[`FLD_RD_ADDR +: 8];
	assign wr_addr   = addr_cfg_r[`FLD_WR_ADDR +: 8];
	assign lst_a     = addr_cfg_r[`FLD_LST_A +: 8];
	assign lst_b     = addr_cfg_r[`FLD_LST_B +: 8];
	assign tsel      = opt_cfg_r[`FLD_TSEL +: 4];
	assign pms_en    = opt_cfg_r[`FLD_PMS_EN];
	assign ack_to_en = opt_cfg_r[`FLD_ACK_TO_EN];

	////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states
	logic       ap_valid;
	logic       dp_wr_r;
	logic [7:0] dp_addr_r;
	logic [2:0] flags;
	logic [7:0] pattern_r;

	assign ap_valid  = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// hold the address phase of a write for its data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_r   <= 1'b0;
			dp_addr_r <= 8'h00;
		end else if (hready) begin
			dp_wr_r   <= ap_valid && hwrite && (haddr[31:8] == 24'h0);
			dp_addr_r <= haddr[7:0];
		end
	end

	// register writes in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_cfg_r <= `RST_ADDR_CFG;
			opt_cfg_r  <= `RST_OPT_CFG;
		end else if (dp_wr_r) begin
			if (dp_addr_r == `OFS_ADDR_CFG) begin
				addr_cfg_r <= hwdata;
			end
			if (dp_addr_r == `OFS_OPT_CFG) begin
				opt_cfg_r <= hwdata[5:0];
			end
		end
	end

	assign sw_clear = dp_wr_r && (dp_addr_r == `OFS_CLEAR) && hwdata[0];

	// read data captured at the address phase, unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_valid && !hwrite) begin
			hrdata <= 32'h0000_0000;
			if (haddr == {24'h0, `OFS_ADDR_CFG}) begin
				hrdata <= addr_cfg_r;
			end
			if (haddr == {24'h0, `OFS_OPT_CFG}) begin
				hrdata <= {26'h0, opt_cfg_r};
			end
			if (haddr == {24'h0, `OFS_STATUS}) begin
				hrdata <= {16'h0, pattern_r, 3'h0, inh_s,
				           |flags, flags};
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// address decode and edges
	logic rd_hit;
	logic wr_hit;
	logic own_hit;
	logic any_act;
	logic rd_q;
	logic wr_q;
	logic inh_q;
	logic pms_q;
	logic rd_start;
	logic wr_start;
	logic lst_a_seen;
	logic lst_b_seen;
	logic good_write;

	// pattern read only on read, pattern write only on write
	assign rd_hit  = rd_act && (addr_s == rd_addr);
	assign wr_hit  = wr_act && (addr_s == wr_addr);
	assign own_hit = rd_hit || wr_hit;
	assign any_act = rd_act || wr_act;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q  <= 1'b0;
			wr_q  <= 1'b0;
			inh_q <= 1'b0;
			pms_q <= 1'b1;
		end else begin
			rd_q  <= rd_act;
			wr_q  <= wr_act;
			inh_q <= inh_s;
			pms_q <= pms_s;
		end
	end

	assign rd_start = rd_act && !rd_q;
	assign wr_start = wr_act && !wr_q;

	// listen addresses count on either strobe
	assign lst_a_seen = (rd_start || wr_start) && (addr_s == lst_a);
	assign lst_b_seen = (rd_start || wr_start) && (addr_s == lst_b);
	assign good_write = wr_start && (addr_s == wr_addr) &&
	                    (data_s == pattern_r);

	////////////////////////////////////////////////////////////////////
	// fault clear sources
	logic clr_any;

	assign clr_any = pclr_act
	               || (inh_q && !inh_s)
	               || xrst_s
	               || sw_clear;

	////////////////////////////////////////////////////////////////////
	// test pattern: inverted after each correct write-back
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pattern_r <= `RST_PATTERN;
		end else if (good_write) begin
			pattern_r <= ~pattern_r;
		end
	end

	assign bus_data_out = pattern_r;
	assign bus_data_oe  = rd_hit;

	////////////////////////////////////////////////////////////////////
	// monitoring time: shortest selected, 1 s when none
	logic [CW-1:0] limit_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			limit_r <= UNIT << 3;
		end else if (tsel[0]) begin
			limit_r <= UNIT;
		end else if (tsel[1]) begin
			limit_r <= UNIT << 1;
		end else if (tsel[2]) begin
			limit_r <= UNIT << 2;
		end else begin
			limit_r <= UNIT << 3;
		end
	end

	////////////////////////////////////////////////////////////////////
	// watchdog timers
	logic [3:0] restart;
	logic [3:0] expired;

	assign restart[TMR_DATA] = clr_any || good_write;
	assign restart[TMR_LSTA] = clr_any || lst_a_seen;
	assign restart[TMR_LSTB] = clr_any || lst_b_seen;
	assign restart[TMR_PMS]  = clr_any || !pms_en ||
	                           (pms_q && !pms_s);

	for (genvar i = 0; i < 4; i++) begin : g_tmr
		watch_timer #(.CW(CW)) u_tmr (
			.hclk    (hclk),
			.hresetn (hresetn),
			.restart (restart[i]),
			.limit   (limit_r),
			.expired (expired[i])
		);
	end

	////////////////////////////////////////////////////////////////////
	// fault flags: set wins over clear, latched until cleared
	logic [2:0] idle_q;
	logic [2:0] set_v;
	faults_s    flt_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_q <= 3'h0;
		end else begin
			idle_q <= {idle_q[1:0], !any_act};
		end
	end

	// trailing own acknowledge is masked by three idle cycles
	assign set_v[0] = expired[TMR_DATA];
	assign set_v[1] = expired[TMR_LSTA] || expired[TMR_LSTB];
	assign set_v[2] = (rd_act && wr_act)
	               || (ack_act && !any_act && &idle_q)
	               || expired[TMR_PMS];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flt_r <= '0;
		end else begin
			flt_r <= (flt_r & {3{!clr_any}}) | set_v;
		end
	end

	assign flags       = flt_r;
	assign data_fault  = flt_r.data;
	assign addr_fault  = flt_r.addr;
	assign ctrl_fault  = flt_r.ctrl;
	assign group_fault = |flt_r;

	////////////////////////////////////////////////////////////////////
	// bus acknowledge, open drain, active low
	logic ack_allow;

	assign ack_allow = !(|flt_r) || !ack_to_en || inh_s;
	assign bus_ack_oe    = own_hit && ack_allow;
	assign bus_ack_out_n = 1'b0;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	listen_quiet_a: assert property (
		any_act && (addr_s == lst_a || addr_s == lst_b) &&
		addr_s != rd_addr && addr_s != wr_addr |-> !bus_ack_oe)
		else $error("listen-only access acknowledged");
	inhibit_ack_a: assert property (
		inh_s && own_hit |-> bus_ack_oe)
		else $error("no acknowledge under output inhibit");
	withhold_ack_a: assert property (
		(data_fault || addr_fault || ctrl_fault) && ack_to_en &&
		!inh_s |-> !bus_ack_oe)
		else $error("acknowledge given despite fault");
	own_ack_a: assert property (
		!group_fault && rd_act && addr_s == rd_addr |-> bus_ack_oe)
		else $error("pattern read not acknowledged");
	invert_pat_a: assert property (
		good_write |=> pattern_r == ~$past(pattern_r))
		else $error("pattern not inverted after write");
	pat_value_a: assert property (
		pattern_r == `RST_PATTERN || pattern_r == `PATTERN_ALT)
		else $error("pattern left its two values");
	data_flt_a: assert property (
		expired[TMR_DATA] |=> data_fault)
		else $error("data timeout did not set fault");
	addr_flt_a: assert property (
		expired[TMR_LSTB] |=> addr_fault)
		else $error("listen timeout did not set fault");
	strobe_clash_a: assert property (
		rd_act && wr_act |=> ctrl_fault)
		else $error("strobe clash not flagged");
	clear_pwr_a: assert property (
		pclr_act |=> (flt_r & ~$past(set_v)) == 3'h0)
		else $error("power clear left a fault");
	clear_inh_a: assert property (
		$fell(inh_s) |=> (flt_r & ~$past(set_v)) == 3'h0)
		else $error("inhibit edge left a fault");
	clear_ext_a: assert property (
		xrst_s |=> (flt_r & ~$past(set_v)) == 3'h0)
		else $error("external reset left a fault");
	latch_a: assert property (
		group_fault && !clr_any |=> group_fault)
		else $error("fault dropped without a clear");
	tsel_a: assert property (
		tsel == 4'h0 |=> limit_r == (UNIT << 3))
		else $error("default monitoring time not 1 s");

	good_write_c: cover property (good_write ##[1:60] rd_hit);
	withheld_c:   cover property (group_fault && own_hit && !bus_ack_oe);
	ctrl_flt_c:   cover property ($rose(ctrl_fault));
	listen_c:     cover property (lst_a_seen ##[1:20] lst_b_seen);
endmodule : bus_monitor

// *** cpu_bus_model.sv ***
// behavioural backplane master with the far-end acknowledging module
`timescale 1ns/10ps
module cpu_bus_model #(
	parameter logic [7:0] LST_A = 8'h55,
	parameter logic [7:0] LST_B = 8'hAA
) (
	input  wire logic       hclk,
	input  wire logic [7:0] bus_data_out,
	input  wire logic       bus_data_oe,
	input  wire logic       bus_ack_out_n,
	input  wire logic       bus_ack_oe,
	output logic      [7:0] bus_addr,
	output logic      [7:0] bus_data_in,
	output logic            read_strobe_n,
	output logic            write_strobe_n,
	output logic            bus_ack_in_n,
	output logic            periph_mem_select
);
	logic [7:0] wdat = 8'h00;
	logic [7:0] last_d = 8'h00;
	logic       wdrv = 1'b0;
	logic       other_ack = 1'b0;
	// idle bus levels at time zero
	initial begin
		bus_addr = 8'h00;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		periph_mem_select = 1'b1;
	end
	// released data lines show the inverse of their last level
	assign bus_data_in = bus_data_oe ? bus_data_out : (wdrv ? wdat : ~last_d);
	assign bus_ack_in_n = ~((bus_ack_oe & ~bus_ack_out_n) | other_ack);
	always @(posedge hclk) last_d <= bus_data_in;
	// one byte access; select line falls during every strobe
	task access(input logic [7:0] a, input logic rd, input logic wr,
		input logic [7:0] wd, output logic [7:0] q, output logic ack);
		bus_addr <= a;
		wdat <= wd;
		wdrv <= wr;
		repeat (2) @(posedge hclk);
		read_strobe_n <= ~rd;
		write_strobe_n <= ~wr;
		periph_mem_select <= 1'b0;
		other_ack <= (a == LST_A) || (a == LST_B);
		repeat (4) @(posedge hclk);
		q = bus_data_in;
		ack = bus_ack_oe && !bus_ack_out_n;
		read_strobe_n <= 1'b1;
		write_strobe_n <= 1'b1;
		periph_mem_select <= 1'b1;
		other_ack <= 1'b0;
		wdrv <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask : access
	// acknowledge with no strobe on the bus
	task stray_ack;
		other_ack <= 1'b1;
		repeat (8) @(posedge hclk);
		other_ack <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask : stray_ack
endmodule : cpu_bus_model

// *** tb_backplane_bus_monitor.sv ***
// self-checking bench of the backplane bus monitor
`timescale 1ns/10ps
`include "bus_monitor_params.svh"
module tb_backplane_bus_monitor;
	import bus_monitor_pkg::*;
	localparam int MON = 200;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        power_clear_n = 1'b1;
	logic        output_inhibit = 1'b0;
	logic        ext_reset = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, bus_data_oe, bus_ack_out_n, bus_ack_oe;
	logic        read_strobe_n, write_strobe_n, bus_ack_in_n;
	logic        periph_mem_select, data_fault, addr_fault, ctrl_fault;
	logic        group_fault, k;
	logic        rd_dp = 1'b0;
	byte_t       bus_addr, bus_data_in, bus_data_out, pat, rda, wra, q;
	logic [31:0] exp_q[$];
	logic [3:0]  tsel[5] = '{4'h1, 4'h6, 4'h4, 4'h8, 4'h0};
	int          mult[5] = '{1, 2, 4, 8, 8};
	int          num_errors = 0;
	int          tests_run = 0;
	always #5 hclk = ~hclk;
	bus_monitor #(.MON_CYC_MIN(MON)) i_dut (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .bus_addr, .bus_data_in, .bus_data_out,
		.bus_data_oe, .read_strobe_n, .write_strobe_n, .bus_ack_in_n,
		.bus_ack_out_n, .bus_ack_oe, .periph_mem_select, .power_clear_n,
		.output_inhibit, .ext_reset, .data_fault, .addr_fault, .ctrl_fault,
		.group_fault);
	cpu_bus_model i_cpu (.hclk, .bus_data_out, .bus_data_oe, .bus_ack_out_n,
		.bus_ack_oe, .bus_addr, .bus_data_in, .read_strobe_n,
		.write_strobe_n, .bus_ack_in_n, .periph_mem_select);
	////////////////////////////////////////////////////////////////////////
	task test_done;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	task check(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			test_done();
		end
	endtask : wait_rdy
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask : ahb
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		ahb(1'b0, a, 32'h0);
	endtask : rd
	task st(input logic d, input logic a, input logic c, input logic i);
		rd(`OFS_STATUS, {16'h0, pat, 3'h0, i, d | a | c, c, a, d});
		check("flags", {data_fault, addr_fault, ctrl_fault, group_fault},
			{d, a, c, d | a | c});
	endtask : st
	task acc(input logic [7:0] a, input logic r, input logic w,
		input logic [7:0] d);
		i_cpu.access(a, r, w, d, q, k);
	endtask : acc
	task round(input logic wb);
		if (wb) begin
			acc(rda, 1'b1, 1'b0, 8'h00);
			check("read ack", k, 1'b1);
			check("pattern", q, pat);
			acc(wra, 1'b0, 1'b1, q);
			check("write ack", k, 1'b1);
			pat = ~pat;
		end
		acc(8'h55, 1'b1, 1'b0, 8'h00);
		check("listen ack", k, 1'b0);
		acc(8'hAA, 1'b0, 1'b1, 8'h00);
		check("listen ack", k, 1'b0);
	endtask : round
	////////////////////////////////////////////////////////////////////////
	// takes the oldest note whenever a read data phase completes
	always @(posedge hclk) begin
		if (rd_dp && hreadyout) begin
			if (exp_q.size() == 0) check("queue", 32'h1, 32'h0);
			else check("hrdata", hrdata, exp_q.pop_front());
			check("hresp", hresp, 1'b0);
		end
		rd_dp <= hsel && hreadyout && htrans[1] && !hwrite;
	end
	// hang guard
	initial begin
		cyc(100000);
		num_errors++;
		test_done();
	end
	// main sequence
	initial begin
		void'($urandom(32'hAF43A63E));
		rda = 8'h01 + 8'($urandom() % 63);
		wra = rda | 8'hC0;
		pat = `RST_PATTERN;
		cyc(20);
		hresetn <= 1'b1;
		cyc(1);
		rd(`OFS_ADDR_CFG, `RST_ADDR_CFG);
		rd(`OFS_OPT_CFG, {26'h0, `RST_OPT_CFG});
		ahb(1'b1, `OFS_STATUS, 32'hFFFF_FFFF);
		st(0, 0, 0, 0);
		rd(8'h10, 32'h0);
		ahb(1'b1, `OFS_ADDR_CFG, {8'hAA, 8'h55, wra, rda});
		ahb(1'b1, `OFS_OPT_CFG, 32'h31);
		ahb(1'b1, `OFS_CLEAR, 32'h1);
		rd(`OFS_ADDR_CFG, {8'hAA, 8'h55, wra, rda});
		acc(rda, 1'b0, 1'b1, 8'h00);
		check("read addr on write", k, 1'b0);
		acc(wra, 1'b1, 1'b0, 8'h00);
		check("write addr on read", k, 1'b0);
		repeat (8) round(1'b1);
		acc(wra, 1'b0, 1'b1, 8'h12);
		check("bad write ack", k, 1'b1);
		st(0, 0, 0, 0);
		repeat (14) round(1'b0);
		st(1, 0, 0, 0);
		acc(rda, 1'b1, 1'b0, 8'h00);
		check("ack withheld", k, 1'b0);
		output_inhibit <= 1'b1;
		cyc(4);
		acc(rda, 1'b1, 1'b0, 8'h00);
		check("ack in inhibit", k, 1'b1);
		st(1, 0, 0, 1);
		output_inhibit <= 1'b0;
		cyc(5);
		st(0, 0, 0, 0);
		ahb(1'b1, `OFS_OPT_CFG, 32'h11);
		cyc(MON + 20);
		st(1, 1, 1, 0);
		acc(rda, 1'b1, 1'b0, 8'h00);
		check("ack kept", k, 1'b1);
		ext_reset <= 1'b1;
		cyc(4);
		ext_reset <= 1'b0;
		cyc(4);
		st(0, 0, 0, 0);
		cyc(MON + 20);
		st(1, 1, 1, 0);
		power_clear_n <= 1'b0;
		cyc(4);
		power_clear_n <= 1'b1;
		cyc(4);
		st(0, 0, 0, 0);
		ahb(1'b1, `OFS_OPT_CFG, 32'h21);
		ahb(1'b1, `OFS_CLEAR, 32'h1);
		acc(8'h10, 1'b1, 1'b1, 8'h00);
		st(0, 0, 1, 0);
		ahb(1'b1, `OFS_CLEAR, 32'h1);
		i_cpu.stray_ack();
		st(0, 0, 1, 0);
		for (int i = 0; i < 5; i++) begin
			ahb(1'b1, `OFS_OPT_CFG, {28'h2, tsel[i]});
			ahb(1'b1, `OFS_CLEAR, 32'h1);
			cyc(MON * mult[i] - 20);
			st(0, 0, 0, 0);
			cyc(40);
			st(1, 1, 0, 0);
		end
		test_done();
	end
endmodule : tb_backplane_bus_monitor
